// [include/adr_pkg.sv]
package adr_pkg;

  // ****************************************************************
  // Register offsets on the serial register port
  // ****************************************************************
  localparam logic [3:0] ADR_OFS_DETAIL = 4'h7;
  localparam logic [3:0] ADR_OFS_VCAL = 4'hC;
  localparam logic [3:0] ADR_OFS_ICAL = 4'hD;
  localparam logic [3:0] ADR_OFS_TRIG = 4'hE;
  localparam logic [3:0] ADR_OFS_STAT = 4'hF;

  // ****************************************************************
  // Detailed status field positions
  // ****************************************************************
  localparam int ADR_BIT_NEG_UV = 11;
  localparam int ADR_BIT_POS_UV = 10;
  localparam int ADR_BIT_NEG_OV = 9;
  localparam int ADR_BIT_POS_OV = 8;
  localparam int ADR_BIT_EXC = 7;
  localparam int ADR_BIT_COMP = 6;
  localparam int ADR_BIT_FLD_OC = 2;
  localparam int ADR_BIT_IN_OC = 1;
  localparam int ADR_BIT_HV_ERR = 0;
  localparam logic [15:0] ADR_DETAIL_RESET = 16'h0000;
  localparam logic [15:0] ADR_DETAIL_USED = 16'h0FC7;

  // ****************************************************************
  // Calibration layout
  // ****************************************************************
  localparam int ADR_VCAL_W = 9;
  localparam int ADR_VCAL_PAR_BIT = 9;
  localparam int ADR_ICAL_W = 15;
  localparam int ADR_ICAL_PAR_BIT = 15;
  localparam int ADR_GAIN_CODES = 16;
  localparam logic [3:0] ADR_GAIN_X4 = 4'hA;

  // ****************************************************************
  // Power-up default mode store
  // ****************************************************************
  localparam int ADR_STAT_FAULT_BIT = 8;
  localparam logic [7:0] ADR_TRIG_KEY = 8'hA5;
  localparam logic [7:0] ADR_CHANGE_LIMIT = 8'h64;
  localparam logic [7:0] ADR_COUNT_INIT = 8'h63;
  localparam int ADR_CLK_MHZ = 25;
  localparam int ADR_PROG_TIME_US = 100;
  localparam logic [11:0] ADR_PROG_CYCLES = 12'(ADR_PROG_TIME_US * ADR_CLK_MHZ);
  localparam logic [11:0] ADR_TIMER_RESET = 12'h000;
  localparam logic [15:0] ADR_RDATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ADR_NV_IDLE = 2'b00,
    ADR_NV_PROG = 2'b01,
    ADR_NV_DONE = 2'b11
  } adr_nv_state_t;

  typedef struct packed {
    adr_nv_state_t state;
    logic [7:0] count;
    logic [11:0] timer;
    logic busy;
  } adr_nv_t;

  typedef struct packed {
    logic [15:0] detail;
    logic [15:0] rdata;
    logic rvalid;
    logic summary;
    logic cur_mode;
    logic loaded;
  } adr_regs_t;

endpackage : adr_pkg

// [core/adr_nvm_mode.sv]
`timescale 1ns/1ps
`default_nettype none

module adr_nvm_mode
  import adr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic change_req,
  input wire logic want_current,
  output logic [7:0] count,
  output logic busy
);

  adr_nv_t cur;
  adr_nv_t nxt;

  // ****************************************************************
  // Change sequencer
  // ****************************************************************
  always_comb begin
    nxt = cur;
    case (cur.state)
      ADR_NV_IDLE: begin
        // A change must flip the mode and needs budget left
        if (change_req && (cur.count != 8'h00) && (want_current != cur.count[0])) begin
          nxt.state = ADR_NV_PROG;
          nxt.timer = ADR_TIMER_RESET;
          nxt.busy = 1'b1;
        end
      end
      ADR_NV_PROG: begin
        if (cur.timer == ADR_PROG_CYCLES - 12'h001) begin
          nxt.state = ADR_NV_DONE;
          nxt.count = cur.count - 8'h01;
        end else begin
          nxt.timer = cur.timer + 12'h001;
        end
      end
      ADR_NV_DONE: begin
        nxt.state = ADR_NV_IDLE;
        nxt.busy = 1'b0;
      end
      default: begin
        nxt.state = ADR_NV_IDLE;
        nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur.state <= ADR_NV_IDLE;
      cur.count <= ADR_COUNT_INIT;
      cur.timer <= ADR_TIMER_RESET;
      cur.busy <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  assign count = cur.count;
  assign busy = cur.busy;

endmodule : adr_nvm_mode

`default_nettype wire

// [core/adr_regs.sv]
// Behaviour
// - Each diagnostic flag latches on its condition, however brief.
// - Latched flags stay set until the detailed status register is read, then clear.
// - Undervoltage neg/pos at bits 11/10, overvoltage neg/pos at 9/8, one means error.
// - Excitation compliance fault bit 7, compensation compliance fault bit 6.
// - Field supply overcurrent bit 2, input overcurrent bit 1.
// - Bit 0 flags an error on the high-voltage input channel.
// - Voltage gain coefficient, 9-bit offset binary, bits 8..0, read only.
// - Bit 9 makes the count of ones in the voltage register odd.
// - Voltage coefficient follows current gain setting; host sets gain first.
// - Current gain coefficient, 15-bit offset binary, bits 14..0, read only.
// - Bit 15 makes the count of ones in the current register odd.
// - Input runs in current mode at power-up unless stored default is voltage.
// - Default status reads even for voltage default, odd for current default.
// - At most 100 default changes (count starts at 99 and stops at 0, so 99 here); remaining count in status bits 7..0.
// - Status bit 8 shows a communication fault during that status read.
// - Masked errors are left out of the summary error bit; here the bit 0 high-voltage error counts even when masked.
`timescale 1ns/1ps
`default_nettype none

module adr_regs
  import adr_pkg::*;
#(
  parameter logic [ADR_GAIN_CODES*ADR_VCAL_W-1:0] VCAL_IMAGE = {ADR_GAIN_CODES{9'h100}},
  parameter logic [ADR_ICAL_W-1:0] ICAL_IMAGE = 15'h4000
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_fault,
  input wire logic [3:0] channel_gain_field,
  input wire logic current_mode_select,
  input wire logic [15:0] error_mask_register,
  input wire logic neg_input_undervoltage,
  input wire logic pos_input_undervoltage,
  input wire logic neg_input_overvoltage,
  input wire logic pos_input_overvoltage,
  input wire logic excitation_compliance_fault,
  input wire logic compensation_compliance_fault,
  input wire logic field_supply_overcurrent,
  input wire logic input_overcurrent,
  input wire logic hv_channel_fault,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic summary_error_bit,
  output logic input_current_mode,
  output logic default_change_busy
);

  adr_regs_t cur;
  adr_regs_t nxt;
  logic [15:0] live;
  logic [15:0] clr;
  logic [15:0] rd_word;
  logic [15:0] vcal_word [ADR_GAIN_CODES];
  logic [15:0] ical_word;
  logic change_req;
  logic [7:0] nv_count;
  logic nv_busy;

  // ****************************************************************
  // Live fault vector
  // ****************************************************************
  always_comb begin
    live = ADR_DETAIL_RESET;
    live[ADR_BIT_NEG_UV] = neg_input_undervoltage;
    live[ADR_BIT_POS_UV] = pos_input_undervoltage;
    live[ADR_BIT_NEG_OV] = neg_input_overvoltage;
    live[ADR_BIT_POS_OV] = pos_input_overvoltage;
    live[ADR_BIT_EXC] = excitation_compliance_fault;
    live[ADR_BIT_COMP] = compensation_compliance_fault;
    live[ADR_BIT_FLD_OC] = field_supply_overcurrent;
    live[ADR_BIT_IN_OC] = input_overcurrent;
    live[ADR_BIT_HV_ERR] = hv_channel_fault;
  end

  // ****************************************************************
  // Factory calibration words
  // ****************************************************************
  for (genvar g = 0; g < ADR_GAIN_CODES; g++) begin : g_vcal
    localparam logic [ADR_VCAL_W-1:0] COEF = VCAL_IMAGE[g*ADR_VCAL_W +: ADR_VCAL_W];
    // Parity bit makes the total number of ones odd
    assign vcal_word[g] = {6'h00, ~^COEF, COEF};
  end

  assign ical_word = {~^ICAL_IMAGE, ICAL_IMAGE};

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rd_word = ADR_RDATA_RESET;
    case (reg_addr)
      ADR_OFS_DETAIL: begin
        rd_word = cur.detail & ADR_DETAIL_USED;
      end
      ADR_OFS_VCAL: begin
        rd_word = vcal_word[channel_gain_field];
      end
      ADR_OFS_ICAL: begin
        rd_word = ical_word;
      end
      ADR_OFS_STAT: begin
        rd_word[7:0] = nv_count;
        rd_word[ADR_STAT_FAULT_BIT] = reg_rd_fault;
      end
      default: begin
        rd_word = ADR_RDATA_RESET;
      end
    endcase
  end

  // ****************************************************************
  // Default-mode trigger
  // ****************************************************************
  // Only the low byte carries the trigger; upper bits are ignored
  assign change_req = reg_wr && (reg_addr == ADR_OFS_TRIG)
                      && (reg_wdata[7:0] == ADR_TRIG_KEY) && !nv_busy;

  adr_nvm_mode u_nvm (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .change_req(change_req),
    .want_current(current_mode_select),
    .count(nv_count),
    .busy(nv_busy)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt = cur;
    clr = (reg_rd && (reg_addr == ADR_OFS_DETAIL)) ? ADR_DETAIL_USED : 16'h0000;
    // A condition in the clearing cycle sets again, so no event is lost
    nxt.detail = (cur.detail & ~clr) | live;
    nxt.rvalid = reg_rd;
    nxt.rdata = reg_rd ? rd_word : cur.rdata;
    // The high-voltage channel error has no mask bit of its own
    nxt.summary = |(live & ADR_DETAIL_USED
                    & ~(error_mask_register & ~(16'h0001 << ADR_BIT_HV_ERR)));
    nxt.loaded = 1'b1;
    // Mode is taken from the store once, just after reset release
    if (!cur.loaded) begin
      nxt.cur_mode = nv_count[0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur.detail <= ADR_DETAIL_RESET;
      cur.rdata <= ADR_RDATA_RESET;
      cur.rvalid <= 1'b0;
      cur.summary <= 1'b0;
      cur.cur_mode <= 1'b1;
      cur.loaded <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  assign reg_rdata = cur.rdata;
  assign reg_rvalid = cur.rvalid;
  assign summary_error_bit = cur.summary;
  assign input_current_mode = cur.cur_mode;
  assign default_change_busy = nv_busy;

endmodule : adr_regs

`default_nettype wire

// [bench/adr_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module adr_regs_checker
  import adr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd_fault,
  input wire logic [15:0] error_mask_register,
  input wire logic neg_input_undervoltage,
  input wire logic input_overcurrent,
  input wire logic hv_channel_fault,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic summary_error_bit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer missing or too long");
  vcal_parity_a: assert property (reg_rvalid && $past(reg_addr) == ADR_OFS_VCAL
    |-> ^reg_rdata[9:0] && reg_rdata[15:10] == 6'h00) else $error("voltage parity wrong");
  ical_parity_a: assert property (reg_rvalid && $past(reg_addr) == ADR_OFS_ICAL
    |-> ^reg_rdata) else $error("current parity wrong");
  stat_fault_a: assert property (reg_rvalid && $past(reg_addr) == ADR_OFS_STAT
    |-> reg_rdata[15:8] == {7'h00, $past(reg_rd_fault)}) else $error("status fault bit wrong");
  detail_rsvd_a: assert property (reg_rvalid && $past(reg_addr) == ADR_OFS_DETAIL
    |-> (reg_rdata & ~ADR_DETAIL_USED) == 16'h0000) else $error("reserved detail bit set");
  flag_hold_a: assert property ($fell(hv_channel_fault) ##1
    (reg_rd && reg_addr == ADR_OFS_DETAIL) |=> reg_rdata[0]) else $error("flag not latched");
  flag_clear_a: assert property ((reg_rd && reg_addr == ADR_OFS_DETAIL && !input_overcurrent)
    ##1 !input_overcurrent ##1 (reg_rd && reg_addr == ADR_OFS_DETAIL && !input_overcurrent)
    |=> !reg_rdata[1]) else $error("flag not cleared by read");
  sum_set_a: assert property (neg_input_undervoltage && !error_mask_register[11]
    |=> summary_error_bit) else $error("summary missed an error");
  sum_mask_a: assert property (error_mask_register == 16'h0FC6 && !hv_channel_fault
    |=> !summary_error_bit) else $error("masked error in summary");
endmodule : adr_regs_checker
bind adr_regs adr_regs_checker chk_u (.ref_clk, .nrst, .reg_rd, .reg_addr, .reg_rd_fault,
  .error_mask_register, .neg_input_undervoltage, .input_overcurrent, .hv_channel_fault,
  .reg_rdata, .reg_rvalid, .summary_error_bit);
`default_nettype wire

// [bench/adr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adr_host_model (
  input wire logic ref_clk,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [3:0] reg_addr = 4'h0,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_rd_fault = 1'b0,
  output logic [3:0] channel_gain_field = 4'h0,
  output logic current_mode_select = 1'b1
);
  // ****************************************************************
  // One strobe cycle, then the bus is released to an inverted pattern
  // ****************************************************************
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic f);
    @(negedge ref_clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    reg_rd_fault = f & !wr;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_fault = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
  task automatic set_gain(input logic [3:0] g);
    @(negedge ref_clk);
    channel_gain_field = g;
  endtask : set_gain
  task automatic set_mode(input logic m);
    @(negedge ref_clk);
    current_mode_select = m;
  endtask : set_mode
endmodule : adr_host_model
`default_nettype wire

// [bench/adr_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adr_regs_tb
  import adr_pkg::*;
;
  localparam logic [14:0] ICAL = 15'h2B5D;
  function automatic logic [8:0] vc(input int g);
    return 9'(g * 37 + 5);
  endfunction : vc
  function automatic logic [ADR_GAIN_CODES*ADR_VCAL_W-1:0] vimg();
    for (int g = 0; g < ADR_GAIN_CODES; g++) vimg[g*9 +: 9] = vc(g);
  endfunction : vimg
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] cond = 16'h0000;
  logic [15:0] mask = 16'h0000;
  logic reg_wr, reg_rd, reg_rd_fault, current_mode_select;
  logic [3:0] reg_addr, channel_gain_field;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic reg_rvalid, summary_error_bit, input_current_mode, default_change_busy;
  logic [8:0] c9;
  logic [15:0] expq[$];
  int bits[9] = '{11, 10, 9, 8, 7, 6, 2, 1, 0};
  int seed, bad_count = 0, n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  adr_host_model host_u (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rd_fault,
    .channel_gain_field, .current_mode_select);
  adr_regs #(.VCAL_IMAGE(vimg()), .ICAL_IMAGE(ICAL)) dut_u (.ref_clk, .nrst, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rd_fault, .channel_gain_field, .current_mode_select,
    .error_mask_register(mask), .neg_input_undervoltage(cond[11]),
    .pos_input_undervoltage(cond[10]), .neg_input_overvoltage(cond[9]),
    .pos_input_overvoltage(cond[8]), .excitation_compliance_fault(cond[7]),
    .compensation_compliance_fault(cond[6]), .field_supply_overcurrent(cond[2]),
    .input_overcurrent(cond[1]), .hv_channel_fault(cond[0]), .reg_rdata, .reg_rvalid,
    .summary_error_bit, .input_current_mode, .default_change_busy);
  task automatic cmp16(input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error reg_rdata expected %h seen %h", e, s);
    end
  endtask : cmp16
  task automatic cmp1(input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error status line expected %b seen %b", e, s);
    end
  endtask : cmp1
  task automatic rd(input logic [3:0] a, input logic f, input logic [15:0] e);
    expq.push_back(e);
    host_u.xfer(1'b0, a, 16'hFFFF, f);
  endtask : rd
  task automatic print_verdict();
    $display("Compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // ****************************************************************
  // Read answer monitor
  // ****************************************************************
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("Error reg_rvalid expected 0 seen 1");
      end else begin
        cmp16(expq.pop_front(), reg_rdata);
      end
    end
  end
  initial begin
    #480000;
    bad_count++;
    print_verdict();
  end
  initial begin
    seed = 56727;
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    cmp1(1'b1, input_current_mode);
    for (int i = 0; i < 12; i++) begin
      v = (i < 9) ? (16'h0001 << bits[i]) : (16'($random(seed)) & ADR_DETAIL_USED);
      mask = 16'($random(seed));
      @(negedge ref_clk);
      cond = v;
      @(negedge ref_clk);
      cmp1(|(v & ~(mask & 16'h0FC6)), summary_error_bit);
      cond = 16'h0000;
      rd(ADR_OFS_DETAIL, 1'b0, v);
      rd(ADR_OFS_DETAIL, 1'b0, 16'h0000);
    end
    host_u.xfer(1'b1, ADR_OFS_VCAL, 16'hFFFF, 1'b0);
    for (int g = 0; g < 16; g++) begin
      host_u.set_gain(4'(g));
      c9 = vc(g);
      rd(ADR_OFS_VCAL, 1'b0, {6'h00, ~^c9, c9});
    end
    host_u.set_gain(ADR_GAIN_X4);
    rd(ADR_OFS_ICAL, 1'b0, {~^ICAL, ICAL});
    rd(4'h3, 1'b0, 16'h0000);
    rd(ADR_OFS_STAT, 1'b1, {8'h01, ADR_COUNT_INIT});
    rd(ADR_OFS_STAT, 1'b0, {8'h00, ADR_COUNT_INIT});
    mask = 16'h0FC6;
    host_u.xfer(1'b1, ADR_OFS_TRIG, {8'h00, ADR_TRIG_KEY}, 1'b0);
    @(negedge ref_clk);
    cmp1(1'b0, default_change_busy);
    host_u.set_mode(1'b0);
    host_u.xfer(1'b1, ADR_OFS_TRIG, {8'hFF, ADR_TRIG_KEY}, 1'b0);
    @(negedge ref_clk);
    cmp1(1'b1, default_change_busy);
    for (int i = 0; i < 3000 && default_change_busy !== 1'b0; i++) @(negedge ref_clk);
    cmp1(1'b0, default_change_busy);
    rd(ADR_OFS_STAT, 1'b0, {8'h00, ADR_COUNT_INIT - 8'h01});
    repeat (4) @(negedge ref_clk);
    print_verdict();
  end
endmodule : adr_regs_tb
`default_nettype wire
